// *** design/vss_sequencer.sv ***
// Top: strap capture, limit readout, rail start-up and shutdown, register port
`timescale 1ns/1ps

module vss_sequencer #(
	parameter int unsigned HOLD_CYC = vss_pkg::HOLD_ZERO_CYC
) (
	input  logic                       clk,
	input  logic                       rst,
	input  logic                       ce,
	input  logic                       supplies_good,
	input  logic                       enable,
	input  logic                       boot_voltage_strap_hi,
	input  logic                       boot_voltage_strap_lo,
	input  logic                       address_swap_strap_lo,
	input  logic                       phase2_sense_neg_hi,
	input  logic                       phase3_sense_neg_hi,
	input  logic [2:0]                 fault_evt,
	input  logic                       adc_valid,
	input  logic [vss_pkg::ADC_W-1:0]  adc_code,
	output logic                       adc_start,
	output logic [1:0]                 adc_sel,
	input  logic [vss_pkg::REG_AW-1:0] reg_addr,
	input  logic [vss_pkg::REG_DW-1:0] reg_wdata,
	input  logic                       reg_wr,
	input  logic                       reg_rd,
	output logic [vss_pkg::REG_DW-1:0] reg_rdata,
	input  logic                       rail_ready_in,
	output logic                       rail_ready_out,
	output logic                       rail_ready_oe_n,
	output logic [vss_pkg::REF_W-1:0]  ref_code,
	output logic                       drivers_en,
	output logic                       gfx_bias_en,
	output logic                       svid_ready,
	output logic                       boot_voltage,
	output logic [3:0]                 core_rail_addr,
	output logic [3:0]                 gfx_rail_addr,
	output logic [1:0]                 phase_count
);
	import vss_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	vss_state_type     state_q;
	vss_state_type     state_d;
	logic              boot_high_q;
	logic [3:0]        core_addr_q;
	logic [3:0]        gfx_addr_q;
	logic [1:0]        phase_q;
	logic [2:0]        fault_q;
	logic [REF_W-1:0]  tgt_q;
	logic              fast_q;
	logic              pend_q;
	logic [REF_W-1:0]  act_tgt_q;
	logic [PER_W-1:0]  act_per_q;
	logic [HOLD_W-1:0] hold_q;
	logic              ready_q;
	logic              drv_q;
	logic              svid_q;
	logic              bias_q;
	logic [REG_DW-1:0] rdata_q;
	logic              od_q;
	logic [REF_W-1:0]  ref_q;
	logic              adc_done;
	logic [ADC_W-1:0]  lim [ADC_CH_N];
	logic              go;
	logic              stop;
	logic              take;
	logic              at_tgt;

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	vss_limit_adc u_adc (
		.clk         (clk),
		.rst         (rst),
		.ce          (ce),
		.adc_valid   (adc_valid),
		.adc_code    (adc_code),
		.adc_start_q (adc_start),
		.adc_sel_q   (adc_sel),
		.done_q      (adc_done),
		.lim_q       (lim)
	);

	// Reference is cleared whenever the rail is off
	vss_ramp u_ramp (
		.clk    (clk),
		.rst    (rst),
		.ce     (ce),
		.clr    (state_q == ST_IDLE),
		.target (act_tgt_q),
		.period (act_per_q),
		.ref_q  (ref_q)
	);

	// ------------------------------------------------------------
	// Strap sampling
	// ------------------------------------------------------------
	// Followed only while supplies are not good, frozen from the rise on
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			boot_high_q <= 1'b0;
			core_addr_q <= RAIL_ADDR_A;
			gfx_addr_q  <= RAIL_ADDR_B;
			phase_q     <= PHASE_THREE;
		end
		else if (ce && !supplies_good)
		begin
			// Between the two thresholds the last decision stands
			if (boot_voltage_strap_hi)
				boot_high_q <= 1'b1;
			else if (boot_voltage_strap_lo)
				boot_high_q <= 1'b0;
			core_addr_q <= address_swap_strap_lo ? RAIL_ADDR_B : RAIL_ADDR_A;
			gfx_addr_q  <= address_swap_strap_lo ? RAIL_ADDR_A : RAIL_ADDR_B;
			if (phase3_sense_neg_hi && phase2_sense_neg_hi)
				phase_q <= PHASE_ONE;
			else if (phase3_sense_neg_hi)
				phase_q <= PHASE_TWO;
			else
				phase_q <= PHASE_THREE;
		end
	end

	// ------------------------------------------------------------
	// Protection latches
	// ------------------------------------------------------------
	// An event in a clearing cycle is kept; enable plays no part
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			fault_q <= '0;
		else if (ce)
			fault_q <= supplies_good ? (fault_q | fault_evt) : fault_evt;
	end

	// ------------------------------------------------------------
	// Command registers
	// ------------------------------------------------------------
	assign go     = supplies_good && enable;
	assign stop   = !enable && state_q != ST_IDLE && state_q != ST_DOWN;
	assign at_tgt = (ref_q == act_tgt_q);
	assign take   = pend_q && ((state_q == ST_WAIT && hold_q == '0)
	                || state_q == ST_CMD || state_q == ST_READY);

	// Target and slew are plain storage
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tgt_q  <= TARGET_RST;
			fast_q <= 1'b0;
		end
		else if (ce && reg_wr)
		begin
			if (reg_addr == REG_TARGET)
				tgt_q <= reg_wdata;
			if (reg_addr == REG_SLEW)
				fast_q <= reg_wdata[0];
		end
	end

	// Pending command; only taken once the interface is up, set wins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pend_q <= 1'b0;
		else if (ce)
		begin
			if (reg_wr && reg_addr == REG_TARGET && svid_q)
				pend_q <= 1'b1;
			else if (take || !supplies_good)
				pend_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (go)
					state_d = boot_high_q ? ST_BOOT : ST_WAIT;
			ST_BOOT:
				if (at_tgt)
					state_d = ST_READY;
			ST_WAIT:
				if (take)
					state_d = ST_CMD;
			ST_CMD:
				if (!take && at_tgt)
					state_d = ST_READY;
			ST_READY:
				state_d = ST_READY;
			ST_DOWN:
				if (ref_q < SHUTDOWN_CODE)
					state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
		if (stop)
			state_d = ST_DOWN;
		if (!supplies_good)
			state_d = ST_IDLE;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_q <= ST_IDLE;
		else if (ce)
			state_q <= state_d;
	end

	// Ramp target and step period for the stage being entered
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			act_tgt_q <= '0;
			act_per_q <= SLOW_CYC;
		end
		else if (ce)
		begin
			if (stop)
			begin
				act_tgt_q <= '0;
				act_per_q <= DOWN_CYC;
			end
			else if (state_q == ST_IDLE && go)
			begin
				// Same boot level for both rails
				act_tgt_q <= boot_high_q ? BOOT_HIGH_CODE : '0;
				act_per_q <= SLOW_CYC;
			end
			else if (take)
			begin
				act_tgt_q <= tgt_q;
				act_per_q <= fast_q ? FAST_CYC : SLOW_CYC;
			end
		end
	end

	// Zero-boot hold; loaded on leaving idle, counts down in wait
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			hold_q <= '0;
		else if (ce)
		begin
			if (state_q == ST_IDLE)
				hold_q <= HOLD_W'(HOLD_CYC);
			else if (state_q == ST_WAIT && hold_q != '0)
				hold_q <= hold_q - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Status outputs
	// ------------------------------------------------------------
	// Registered next state, so loss of supplies or enable drops ready next edge
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ready_q <= 1'b0;
			drv_q   <= 1'b0;
			svid_q  <= 1'b0;
			od_q    <= 1'b0;
		end
		else if (ce)
		begin
			ready_q <= (state_d == ST_READY);
			drv_q   <= (state_d != ST_IDLE);
			svid_q  <= (state_d != ST_IDLE);
			od_q    <= 1'b0;
		end
	end

	// Bias on the graphics limit pin follows the finished conversion
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			bias_q <= 1'b0;
		else if (ce)
			bias_q <= adc_done;
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	// Limits are only reported; nothing compares them with load or heat
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata_q <= '0;
		else if (ce)
		begin
			rdata_q <= '0;
			if (reg_rd)
			begin
				case (reg_addr)
					REG_CORE_LIM: rdata_q <= lim[ADC_CH_CORE];
					REG_GFX_LIM:  rdata_q <= lim[ADC_CH_GFX];
					REG_TEMP_LIM: rdata_q <= lim[ADC_CH_TEMP];
					REG_STATUS:   rdata_q <= {2'h0, svid_q, rail_ready_in,
					                          adc_done, fault_q};
					REG_TARGET:   rdata_q <= tgt_q;
					REG_SLEW:     rdata_q <= {7'h00, fast_q};
					REG_REF:      rdata_q <= ref_q;
					REG_CONFIG:   rdata_q <= {4'h0, phase_q,
					                          core_addr_q == RAIL_ADDR_B, boot_high_q};
					default:      rdata_q <= '0;
				endcase
			end
		end
	end

	// Open drain: enable low pulls the line down while not ready
	assign rail_ready_out  = od_q;
	assign rail_ready_oe_n = ready_q;
	assign reg_rdata       = rdata_q;
	assign ref_code        = ref_q;
	assign drivers_en      = drv_q;
	assign gfx_bias_en     = bias_q;
	assign svid_ready      = svid_q;
	assign boot_voltage    = boot_high_q;
	assign core_rail_addr  = core_addr_q;
	assign gfx_rail_addr   = gfx_addr_q;
	assign phase_count     = phase_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_LIMIT_ONCE: assert property (adc_done && ce |=> $stable(lim[ADC_CH_TEMP]))
		else $error("limit code changed after conversion");
	AST_BIAS_ON: assert property ($rose(adc_done) && ce |=> gfx_bias_en)
		else $error("bias not on after conversion");
	AST_BOOT_HELD: assert property (supplies_good && $past(supplies_good) |-> $stable(boot_high_q))
		else $error("boot choice moved while supplies good");
	AST_SWAP_ADDR: assert property (!supplies_good && address_swap_strap_lo && ce
		|=> core_rail_addr == RAIL_ADDR_B && gfx_rail_addr == RAIL_ADDR_A)
		else $error("rail addresses not swapped");
	AST_ONE_PHASE: assert property (!supplies_good && ce && phase2_sense_neg_hi
		&& phase3_sense_neg_hi |=> phase_count == PHASE_ONE)
		else $error("phase count not one");
	AST_NO_START: assert property (state_q == ST_IDLE && !go && ce |=> state_q == ST_IDLE)
		else $error("start-up without supplies and enable");
	AST_ZERO_HOLD: assert property (state_q == ST_WAIT |-> ref_q == '0)
		else $error("reference moved during zero hold");
	AST_DOWN_STEP: assert property (state_q == ST_DOWN && $changed(ref_q)
		|-> ref_q == $past(ref_q) - 1'b1)
		else $error("ramp-down step wrong");
	AST_SHUT: assert property (state_q == ST_DOWN && ref_q < SHUTDOWN_CODE
		&& supplies_good && ce |=> !drivers_en)
		else $error("drivers still on below shutdown level");
	AST_READY_DROP: assert property ((!supplies_good || !enable) && ce |=> rail_ready_oe_n == 1'b0)
		else $error("rail-ready not released");
	AST_POWER_DOWN: assert property (!supplies_good && ce |=> state_q == ST_IDLE && !drivers_en)
		else $error("still active without supplies");
	AST_FAULT_KEEP: assert property (supplies_good && fault_q[0] && ce |=> fault_q[0])
		else $error("protection latch cleared with supplies good");
	AST_READY_AT: assert property ($rose(ready_q) |-> ref_q == act_tgt_q)
		else $error("ready before target reached");

	COV_READY: cover property ($rose(ready_q));
	COV_CMD: cover property (state_q == ST_WAIT ##1 state_q == ST_CMD);
	COV_SHUT: cover property (state_q == ST_DOWN ##1 state_q == ST_IDLE);
endmodule : vss_sequencer

// *** design/vss_pkg.sv ***
// Package: constants and state type for the start-up sequencer
package vss_pkg;
	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int REF_W  = 8;
	localparam int PER_W  = 5;
	localparam int HOLD_W = 16;
	localparam int ADC_W  = 8;
	localparam int REG_AW = 8;
	localparam int REG_DW = 8;

	// ------------------------------------------------------------
	// Timing and reference scale
	// ------------------------------------------------------------
	localparam int CLK_NS        = 100;
	localparam int REF_LSB_UV    = 5000;   // Reference code step, 5 mV
	localparam int BOOT_HIGH_MV  = 1100;
	localparam int SHUTDOWN_MV   = 200;
	localparam int DOWN_RATE_UV  = 3125;   // Microvolts per microsecond
	localparam int SLOW_STEP_NS  = 2000;
	localparam int FAST_STEP_NS  = 500;
	localparam int HOLD_ZERO_US  = 2000;
	localparam int DOWN_STEP_NS  = REF_LSB_UV * 1000 / DOWN_RATE_UV;
	localparam logic [REF_W-1:0] BOOT_HIGH_CODE = REF_W'(BOOT_HIGH_MV * 1000 / REF_LSB_UV);
	localparam logic [REF_W-1:0] SHUTDOWN_CODE  = REF_W'(SHUTDOWN_MV * 1000 / REF_LSB_UV);
	localparam logic [PER_W-1:0] DOWN_CYC = PER_W'((DOWN_STEP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [PER_W-1:0] SLOW_CYC = PER_W'((SLOW_STEP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [PER_W-1:0] FAST_CYC = PER_W'((FAST_STEP_NS + CLK_NS - 1) / CLK_NS);
	localparam int unsigned HOLD_ZERO_CYC = HOLD_ZERO_US * 1000 / CLK_NS;

	// ------------------------------------------------------------
	// Limit converter, addresses, phases
	// ------------------------------------------------------------
	localparam int ADC_LEVELS = 255;
	localparam int ADC_LSB_UV = 5000000 / ADC_LEVELS;   // One amp or one degree
	localparam int ADC_CH_N   = 3;
	localparam logic [1:0] ADC_CH_CORE = 2'h0;
	localparam logic [1:0] ADC_CH_GFX  = 2'h1;
	localparam logic [1:0] ADC_CH_TEMP = 2'h2;
	localparam logic [3:0] RAIL_ADDR_A = 4'h0;
	localparam logic [3:0] RAIL_ADDR_B = 4'h1;
	localparam logic [1:0] PHASE_ONE   = 2'h1;
	localparam logic [1:0] PHASE_TWO   = 2'h2;
	localparam logic [1:0] PHASE_THREE = 2'h3;

	// ------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------
	localparam logic [REG_AW-1:0] REG_CORE_LIM = 8'h00;
	localparam logic [REG_AW-1:0] REG_GFX_LIM  = 8'h01;
	localparam logic [REG_AW-1:0] REG_TEMP_LIM = 8'h02;
	localparam logic [REG_AW-1:0] REG_STATUS   = 8'h03;
	localparam logic [REG_AW-1:0] REG_TARGET   = 8'h04;
	localparam logic [REG_AW-1:0] REG_SLEW     = 8'h05;
	localparam logic [REG_AW-1:0] REG_REF      = 8'h06;
	localparam logic [REG_AW-1:0] REG_CONFIG   = 8'h07;
	localparam logic [REF_W-1:0]  TARGET_RST   = 8'h00;

	// Gray codes along idle, wait, command ramp, ready, ramp-down
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_WAIT  = 3'h1,
		ST_CMD   = 3'h3,
		ST_READY = 3'h2,
		ST_DOWN  = 3'h6,
		ST_BOOT  = 3'h4
	} vss_state_type;
endpackage : vss_pkg

// *** design/vss_ramp.sv ***
// Reference ramp: steps the reference code one LSB per period toward target
`timescale 1ns/1ps

module vss_ramp (
	input  logic                      clk,
	input  logic                      rst,
	input  logic                      ce,
	input  logic                      clr,
	input  logic [vss_pkg::REF_W-1:0] target,
	input  logic [vss_pkg::PER_W-1:0] period,
	output logic [vss_pkg::REF_W-1:0] ref_q
);
	import vss_pkg::*;

	logic [PER_W-1:0] cnt_q;

	// Period counter, idle while at target so a new target starts a full period
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_q <= '0;
		else if (ce)
		begin
			if (clr || ref_q == target || cnt_q >= period - 1'b1)
				cnt_q <= '0;
			else
				cnt_q <= cnt_q + 1'b1;
		end
	end

	// One code step per elapsed period, in the direction of the target
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ref_q <= '0;
		else if (ce)
		begin
			if (clr)
				ref_q <= '0;
			else if (ref_q != target && cnt_q >= period - 1'b1)
				ref_q <= (ref_q < target) ? ref_q + 1'b1 : ref_q - 1'b1;
		end
	end
endmodule : vss_ramp

// *** design/vss_limit_adc.sv ***
// One-shot sequencer for the three limit pin conversions
`timescale 1ns/1ps

module vss_limit_adc (
	input  logic                      clk,
	input  logic                      rst,
	input  logic                      ce,
	input  logic                      adc_valid,
	input  logic [vss_pkg::ADC_W-1:0] adc_code,
	output logic                      adc_start_q,
	output logic [1:0]                adc_sel_q,
	output logic                      done_q,
	output logic [vss_pkg::ADC_W-1:0] lim_q [vss_pkg::ADC_CH_N]
);
	import vss_pkg::*;

	logic busy_q;

	// Walk the channels once; done never clears, so the pins are not reread
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			adc_start_q <= 1'b0;
			busy_q      <= 1'b0;
			adc_sel_q   <= ADC_CH_CORE;
			done_q      <= 1'b0;
		end
		else if (ce)
		begin
			adc_start_q <= !done_q && !busy_q;
			if (!done_q && !busy_q)
				busy_q <= 1'b1;
			else if (busy_q && adc_valid)
			begin
				busy_q    <= 1'b0;
				done_q    <= (adc_sel_q == ADC_CH_TEMP);
				adc_sel_q <= adc_sel_q + 2'h1;
			end
		end
	end

	// Each code is a plain count of amps or degrees
	for (genvar g = 0; g < ADC_CH_N; g++)
	begin : g_lim
		always_ff @(posedge clk or posedge rst)
		begin
			if (rst)
				lim_q[g] <= '0;
			else if (ce && busy_q && adc_valid && adc_sel_q == 2'(g))
				lim_q[g] <= adc_code;
		end
	end
endmodule : vss_limit_adc

// *** sim/vss_conv_model.sv ***
// Behavioural limit converter that answers the sequencer's start pulses
`timescale 1ns/1ps

module vss_conv_model (
	input  logic       clk,
	input  logic       rst,
	input  logic       adc_start,
	input  logic [1:0] adc_sel,
	input  logic [7:0] pin_code [3],
	output logic       adc_valid,
	output logic [7:0] adc_code
);
	logic [2:0] cnt_q;
	logic [1:0] ch_q;

	// Later channels answer more slowly; code line toggles outside valid
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q     <= 3'h0;
			ch_q      <= 2'h0;
			adc_valid <= 1'b0;
			adc_code  <= 8'h5a;
		end
		else if (adc_start)
		begin
			cnt_q     <= {adc_sel, 1'b1};   // 1, 3 or 5 cycles to answer
			ch_q      <= adc_sel;
			adc_valid <= 1'b0;
			adc_code  <= ~adc_code;
		end
		else if (cnt_q == 3'h1)
		begin
			cnt_q     <= 3'h0;
			adc_valid <= 1'b1;
			adc_code  <= pin_code[ch_q];
		end
		else
		begin
			cnt_q     <= cnt_q - {2'h0, cnt_q != 3'h0};
			adc_valid <= 1'b0;
			adc_code  <= ~adc_code;
		end
	end
endmodule : vss_conv_model

// *** sim/vss_sequencer_tb.sv ***
// Self-checking bench for the start-up sequencer
`timescale 1ns/1ps

module vss_sequencer_tb;
	import vss_pkg::*;
	logic       clk = 1'b0, rst = 1'b1, ce = 1'b1, supplies_good = 1'b0, enable = 1'b0;
	logic       bs_hi = 1'b0, bs_lo = 1'b0, swap_lo = 1'b0, ph2 = 1'b0, ph3 = 1'b0;
	logic [2:0] fault_evt = 3'h0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ref_code;
	logic       reg_wr = 1'b0, reg_rd = 1'b0, adc_valid, adc_start, rail_ready_in;
	logic       rail_ready_out, rail_ready_oe_n, drivers_en, gfx_bias_en, svid_ready;
	logic       boot_voltage;
	logic [7:0] adc_code, lim_exp [3];
	logic [7:0] pin_code [3] = '{8'd45, 8'd90, 8'd120};
	logic [3:0] core_addr, gfx_addr;
	logic [1:0] adc_sel, phase_count;
	int         n_mismatch = 0, total_checks = 0, n_start = 0;

	// Clock, pull-up on the rail-ready wire, start pulse counter
	always #50 clk = ~clk;
	assign rail_ready_in = rail_ready_oe_n ? 1'b1 : rail_ready_out;
	always @(posedge clk) if (adc_start === 1'b1) n_start++;

	vss_sequencer #(.HOLD_CYC(20)) vss_sequencer_inst (.clk(clk), .rst(rst), .ce(ce),
		.supplies_good(supplies_good), .enable(enable), .boot_voltage_strap_hi(bs_hi),
		.boot_voltage_strap_lo(bs_lo), .address_swap_strap_lo(swap_lo),
		.phase2_sense_neg_hi(ph2), .phase3_sense_neg_hi(ph3), .fault_evt(fault_evt),
		.adc_valid(adc_valid), .adc_code(adc_code), .adc_start(adc_start),
		.adc_sel(adc_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rail_ready_in(rail_ready_in),
		.rail_ready_out(rail_ready_out), .rail_ready_oe_n(rail_ready_oe_n),
		.ref_code(ref_code), .drivers_en(drivers_en), .gfx_bias_en(gfx_bias_en),
		.svid_ready(svid_ready), .boot_voltage(boot_voltage), .core_rail_addr(core_addr),
		.gfx_rail_addr(gfx_addr), .phase_count(phase_count));

	vss_conv_model vss_conv_model_inst (.clk(clk), .rst(rst), .adc_start(adc_start),
		.adc_sel(adc_sel), .pin_code(pin_code), .adc_valid(adc_valid), .adc_code(adc_code));

	// -----------------------------------------------------------------
	// Shared helpers
	// -----------------------------------------------------------------
	task automatic test_done();
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe is taken
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd

	// Order: supplies_good, enable, boot hi, boot lo, swap, phase2, phase3
	task automatic pins(input logic [6:0] v);
		@(posedge clk);
		{supplies_good, enable, bs_hi, bs_lo, swap_lo, ph2, ph3} <= v;
	endtask : pins

	// Bounded wait so a stuck ramp ends in a mismatch, not a hang
	task automatic wait_ref(input logic [7:0] v);
		for (int i = 0; i < 6000 && ref_code !== v; i++)
			@(negedge clk);
		chk("ref_code reached", ref_code, v);
	endtask : wait_ref

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic t_limits();
		logic [7:0] d;
		cyc(40);
		lim_exp = pin_code;
		chk("gfx_bias_en", gfx_bias_en, 1'b1);
		for (int c = 0; c < 3; c++)
		begin
			rd(8'(c), d);
			chk("limit reg", d, lim_exp[c]);
		end
		wr(REG_CORE_LIM, 8'hff);
		rd(REG_CORE_LIM, d);
		chk("read-only limit", d, lim_exp[0]);
		rd(8'h20, d);
		chk("unmapped read", d, 8'h00);
		pin_code = '{8'd7, 8'd8, 8'd9};
		cyc(40);
		chk("start pulses", n_start, 3);
	endtask : t_limits

	task automatic t_straps();
		logic [7:0] d;
		pins(7'b0010101);
		cyc(3);
		chk("phase while low", phase_count, PHASE_TWO);
		pins(7'b1010101);
		cyc(2);
		chk("boot_voltage", boot_voltage, 1'b1);
		chk("core addr", core_addr, RAIL_ADDR_B);
		chk("gfx addr", gfx_addr, RAIL_ADDR_A);
		chk("phases", phase_count, PHASE_TWO);
		pins(7'b1001010);
		cyc(3);
		chk("boot held", boot_voltage, 1'b1);
		chk("swap held", core_addr, RAIL_ADDR_B);
		chk("phase held", phase_count, PHASE_TWO);
		rd(REG_CONFIG, d);
		chk("config", d, 8'h0b);
	endtask : t_straps

	task automatic t_boot_up();
		cyc(5);
		chk("no start without enable", drivers_en, 1'b0);
		pins(7'b1101010);
		cyc(2);
		chk("svid_ready", svid_ready, 1'b1);
		chk("drivers_en", drivers_en, 1'b1);
		@(posedge clk) fault_evt <= 3'h1;
		@(posedge clk) fault_evt <= 3'h0;
		wait_ref(8'd219);
		chk("not ready early", rail_ready_oe_n, 1'b0);
		wait_ref(BOOT_HIGH_CODE);
		cyc(1);
		chk("rail ready", rail_ready_in, 1'b1);
		cyc(100);
		chk("boot hold", ref_code, BOOT_HIGH_CODE);
	endtask : t_boot_up

	task automatic t_down();
		logic [7:0] r0, d;
		pins(7'b1001010);
		cyc(2);
		chk("ready drop on enable", rail_ready_oe_n, 1'b0);
		chk("rail line low", rail_ready_in, 1'b0);
		r0 = ref_code;
		cyc(160);
		chk("down steps", 32'(r0 - ref_code), 32'd10);
		// Clock enable low must freeze the ramp in mid-step
		@(posedge clk) ce <= 1'b0;
		@(negedge clk) r0 = ref_code;
		cyc(40);
		chk("frozen by ce", ref_code, r0);
		@(posedge clk) ce <= 1'b1;
		for (int i = 0; i < 4000 && drivers_en !== 1'b0; i++)
			@(negedge clk);
		chk("off below level", {7'h0, ref_code < SHUTDOWN_CODE}, 8'h01);
		rd(REG_STATUS, d);
		chk("latch kept", d[0], 1'b1);
	endtask : t_down

	task automatic t_zero_boot();
		logic [7:0] d;
		int n;
		pins(7'b0001011);
		cyc(2);
		rd(REG_STATUS, d);
		chk("latch cleared", d[0], 1'b0);
		pins(7'b1001011);
		cyc(2);
		chk("boot zero", boot_voltage, 1'b0);
		chk("core addr", core_addr, RAIL_ADDR_A);
		chk("phases", phase_count, PHASE_ONE);
		wr(REG_SLEW, 8'h01);
		pins(7'b1101011);
		cyc(2);
		wr(REG_TARGET, 8'd60);
		cyc(12);
		chk("zero hold", ref_code, 8'h00);
		wait_ref(8'd10);
		for (n = 0; n < 500 && ref_code !== 8'd20; n++)
			@(negedge clk);
		chk("fast slew cycles", n, 50);
		wait_ref(8'd60);
		cyc(1);
		chk("ready at target", rail_ready_oe_n, 1'b1);
		// Retarget at slow slew: one code per 2000 ns, ready stays up
		wr(REG_SLEW, 8'h00);
		wr(REG_TARGET, 8'd62);
		wait_ref(8'd61);
		for (n = 0; n < 500 && ref_code !== 8'd62; n++)
			@(negedge clk);
		chk("slow slew cycles", n, 20);
		chk("ready kept on retarget", rail_ready_oe_n, 1'b1);
		pins(7'b0101011);
		cyc(2);
		chk("ready drop on supply", rail_ready_oe_n, 1'b0);
		cyc(1);
		chk("all off", drivers_en, 1'b0);
		rd(REG_TEMP_LIM, d);
		chk("limit unchanged", d, lim_exp[2]);
	endtask : t_zero_boot

	// -----------------------------------------------------------------
	// Main sequence and watchdog
	// -----------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_limits();
		t_straps();
		t_boot_up();
		t_down();
		t_zero_boot();
		test_done();
	end

	// Whole run needs about 8000 cycles; far beyond that means a hang
	initial
	begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		test_done();
	end
endmodule : vss_sequencer_tb
